// File: src/elg_cfg.svh
// constants for the light-curtain / emergency-stop interlock
// assumes a 250 MHz system clock; included by bare name
//
// Function
// (RL1) The motor may only be switched on while the light curtain is clear and the emergency stop is released.
// (RL2) With both conditions met, a start pulse from the host energises the motor output and raises the controller enable.
// (RL3) Losing a condition drops the combined output and removes the controller enable at once; both contactor outputs stay on for the off-delay.
// (RL4) The motor output is de-energised only after a fixed 500 ms off-delay.
// (RL5) The series break contacts of both contactors form a feedback loop that is closed only when both have dropped out.
// (RL6) The start pulse is only accepted while the start conditions hold and the feedback loop is closed.
// (RL7) A bridged or overridden sensor contact is flagged as an error at the next actuation and holds both contactor outputs low.
// (RL8) A supply short onto any sensor input is an error that forces every safety output low.
// (RL9) A supply short onto any safety output is detected and forces all safety outputs low.
// (RL10) Curtain channels carry test pulses 0 and 1, stop channels pulses 2 and 3, and a channel missing its own pulse is an error.
// (RL11) The motor output is a redundant two-channel output watched by the feedback loop; the controller enable is single-pole.
// (RL12) All sensor, feedback and reset inputs are synchronised, and the start pulse acts on its rising edge only; the code uses i_resetn unsynchronised.
// (RL13) A dual-channel sensor counts as actuated whenever either channel reads open.
`ifndef ELG_CFG_SVH
`define ELG_CFG_SVH

`define ELG_CLK_MHZ 250
`define ELG_OFF_DELAY_MS 500
`define ELG_OFF_DELAY_CYC (`ELG_OFF_DELAY_MS * 1000 * `ELG_CLK_MHZ)
`define ELG_TP_PERIOD_US 1000
`define ELG_TP_PERIOD_CYC (`ELG_TP_PERIOD_US * `ELG_CLK_MHZ)
`define ELG_TP_LOW_US 1
`define ELG_TP_LOW_CYC (`ELG_TP_LOW_US * `ELG_CLK_MHZ)
`define ELG_TP_SETTLE_CYC 32
`define ELG_FB_SETTLE_US 100
`define ELG_FB_SETTLE_CYC (`ELG_FB_SETTLE_US * `ELG_CLK_MHZ)
`define ELG_NUM_CH 4

`endif

// File: src/elg_pkg.sv
// types for the light-curtain / emergency-stop interlock
// assumes elg_cfg.svh supplies the numeric constants
package elg_pkg;
	typedef enum logic [1:0] {
		ELG_ST_IDLE = 2'b00,
		ELG_ST_RUN = 2'b01,
		ELG_ST_DELAY = 2'b10,
		ELG_ST_FAULT = 2'b11
	} elg_state_e;
endpackage : elg_pkg

// File: src/elg_tp_if.sv
// test-pulse bundle between the interlock top and the channel checker
// assumes one clock domain
`timescale 1ns/1ps
interface elg_tp_if;
	logic [3:0] pulse_low;
	logic [3:0] sample;
	logic [3:0] chan_in;
	logic [3:0] chan_err;
	modport src (output pulse_low, output sample, input chan_in, input chan_err);
	modport chk (input pulse_low, input sample, output chan_in, output chan_err);
endinterface : elg_tp_if

// File: src/elg_tp_check.sv
// per-channel test-pulse return checker
// assumes channel inputs already synchronised by the top
`timescale 1ns/1ps
module elg_tp_check #(
	parameter int NUM_CH = 4
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// synchronised channel levels
	input wire logic [NUM_CH-1:0] i_chan,
	// test-pulse bundle
	elg_tp_if.chk tp
);
	logic [NUM_CH-1:0] err_ff;

	assign tp.chan_in = i_chan;
	assign tp.chan_err = err_ff;

	// ----------------------------------------------------------------
	// a channel that stays high while its own pulse is low is shorted
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			err_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (tp.sample[i] && tp.pulse_low[i] && tp.chan_in[i]) begin
					err_ff[i] <= 1'b1; // [RL10] [RL8]
				end
			end
		end
	end
endmodule : elg_tp_check

// File: src/elg_interlock.sv
// light-curtain and emergency-stop interlock with delayed motor release
// assumes asynchronous level pins from the field and the host
`timescale 1ns/1ps
`include "elg_cfg.svh"
module elg_interlock import elg_pkg::*; #(
	parameter int OFF_DELAY_CYC = `ELG_OFF_DELAY_CYC,
	parameter int TP_PERIOD_CYC = `ELG_TP_PERIOD_CYC,
	parameter int TP_LOW_CYC = `ELG_TP_LOW_CYC,
	parameter int FB_SETTLE_CYC = `ELG_FB_SETTLE_CYC
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// sensor channels, normally closed, high when healthy
	input wire logic i_curtain_channel_a_input,
	input wire logic i_curtain_channel_b_input,
	input wire logic i_estop_channel_a_input,
	input wire logic i_estop_channel_b_input,
	// contactor loop and host start
	input wire logic i_contactor_feedback_input,
	input wire logic i_start_pulse,
	// readback of safety outputs
	input wire logic [3:0] i_out_readback,
	// test pulse feeds to sensors
	output logic [3:0] o_test_pulse,
	// safety outputs
	output logic o_combined_condition_output,
	output logic o_motor_contactor_output_a,
	output logic o_motor_contactor_output_b,
	output logic o_controller_enable,
	// diagnostics
	output logic o_fault,
	output logic [3:0] o_chan_err
);
	localparam int NCH = `ELG_NUM_CH;
	localparam int SETTLE = `ELG_TP_SETTLE_CYC;

	elg_tp_if tp();

	logic [NCH-1:0] meta_ff;
	logic [NCH-1:0] chan_ff;
	logic [2:1] aux_meta_ff;
	logic [2:1] aux_ff;
	logic [1:0] fill_ff;
	logic start_prev_ff;
	logic [31:0] tp_cnt_ff;
	logic [1:0] tp_sel_ff;
	logic [NCH-1:0] pulse_low_ff;
	logic [NCH-1:0] sample_ff;
	logic [NCH-1:0] pl_d1_ff;
	logic [NCH-1:0] pl_d2_ff;
	logic [NCH-1:0] tp_mask;
	logic [31:0] dly_cnt_ff;
	logic [31:0] fb_cnt_ff;
	logic fb_err_ff;
	logic [3:0] rb_err_ff;
	logic disc_err_ff;
	logic [1:0] last_cur_ff;
	logic [1:0] last_est_ff;
	logic cur_seen_open_ff;
	logic est_seen_open_ff;
	elg_state_e state_ff;
	elg_state_e nxt_state;
	logic comb_ff;
	logic mot_a_ff;
	logic mot_b_ff;
	logic en_ff;
	logic fault_ff;
	logic [3:0] chan_err_ff;

	logic curtain_ok;
	logic estop_ok;
	logic cond_ok;
	logic fb_closed;
	logic start_rise;
	logic any_fault;
	logic motor_on;
	logic [3:0] drv;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_ff <= '0;
			chan_ff <= '0;
			// start bit resets high: a start line held through reset gives no edge
			aux_meta_ff <= 2'b10;
			aux_ff <= 2'b10;
			fill_ff <= '0;
		end else begin
			meta_ff <= {i_estop_channel_b_input, i_estop_channel_a_input,
				i_curtain_channel_b_input, i_curtain_channel_a_input}; // [RL12]
			chan_ff <= meta_ff;
			aux_meta_ff <= {i_start_pulse, i_contactor_feedback_input};
			aux_ff <= aux_meta_ff;
			fill_ff <= {fill_ff[0], 1'b1};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			start_prev_ff <= 1'b1;
		end else begin
			start_prev_ff <= aux_ff[2];
		end
	end

	assign start_rise = aux_ff[2] && !start_prev_ff; // [RL12]
	assign fb_closed = aux_ff[1]; // [RL5]
	// either open channel removes the condition; pulse-low windows are masked
	// mask covers the pulse and the two synchroniser stages behind it
	assign tp_mask = pulse_low_ff | pl_d1_ff | pl_d2_ff;
	assign curtain_ok = (chan_ff[0] || tp_mask[0]) && (chan_ff[1] || tp_mask[1]); // [RL13]
	assign estop_ok = (chan_ff[2] || tp_mask[2]) && (chan_ff[3] || tp_mask[3]); // [RL13]
	assign cond_ok = curtain_ok && estop_ok; // [RL1]

	// ----------------------------------------------------------------
	// test pulse generator: one channel low at a time, in turn
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tp_cnt_ff <= '0;
			tp_sel_ff <= '0;
			pulse_low_ff <= '0;
			sample_ff <= '0;
			pl_d1_ff <= '0;
			pl_d2_ff <= '0;
		end else begin
			pulse_low_ff <= '0;
			sample_ff <= '0;
			pl_d1_ff <= pulse_low_ff;
			pl_d2_ff <= pl_d1_ff;
			if (tp_cnt_ff == 32'(TP_PERIOD_CYC - 1)) begin
				tp_cnt_ff <= '0;
				tp_sel_ff <= tp_sel_ff + 2'h1;
			end else begin
				tp_cnt_ff <= tp_cnt_ff + 32'h1;
			end
			if (tp_cnt_ff < 32'(TP_LOW_CYC + SETTLE)) begin
				pulse_low_ff[tp_sel_ff] <= 1'b1; // [RL10]
				sample_ff[tp_sel_ff] <= (tp_cnt_ff >= 32'(SETTLE)) && (tp_cnt_ff < 32'(TP_LOW_CYC + SETTLE - 1));
			end
		end
	end

	assign tp.pulse_low = pulse_low_ff;
	assign tp.sample = sample_ff;

	elg_tp_check #(
		.NUM_CH(NCH)
	) u_check (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_chan(chan_ff),
		.tp(tp.chk)
	);

	// ----------------------------------------------------------------
	// bridged contact: pair must close again in the same cycle on each actuation
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			disc_err_ff <= 1'b0;
			last_cur_ff <= 2'b11;
			last_est_ff <= 2'b11;
			cur_seen_open_ff <= 1'b0;
			est_seen_open_ff <= 1'b0;
		end else begin
			last_cur_ff <= chan_ff[1:0] | tp_mask[1:0];
			last_est_ff <= chan_ff[3:2] | tp_mask[3:2];
			// synchroniser fill after reset is not an actuation
			if (!curtain_ok && fill_ff[1]) begin
				cur_seen_open_ff <= 1'b1;
			end else begin
				cur_seen_open_ff <= 1'b0;
			end
			if (!estop_ok && fill_ff[1]) begin
				est_seen_open_ff <= 1'b1;
			end else begin
				est_seen_open_ff <= 1'b0;
			end
			// actuation ends with only one channel open in its last open cycle
			if (cur_seen_open_ff && curtain_ok && (last_cur_ff == 2'b01 || last_cur_ff == 2'b10)) begin
				disc_err_ff <= 1'b1; // [RL7]
			end
			if (est_seen_open_ff && estop_ok && (last_est_ff == 2'b01 || last_est_ff == 2'b10)) begin
				disc_err_ff <= 1'b1; // [RL7]
			end
		end
	end

	// ----------------------------------------------------------------
	// output readback and contactor loop supervision
	// ----------------------------------------------------------------
	assign drv = {en_ff, mot_b_ff, mot_a_ff, comb_ff};

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rb_err_ff <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!drv[i] && i_out_readback[i]) begin
					rb_err_ff[i] <= 1'b1; // [RL9]
				end
			end
		end
	end

	assign motor_on = mot_a_ff || mot_b_ff;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fb_cnt_ff <= '0;
			fb_err_ff <= 1'b0;
		end else begin
			// loop must open while energised and close once released
			if (motor_on == fb_closed) begin
				if (fb_cnt_ff == 32'(FB_SETTLE_CYC - 1)) begin
					fb_err_ff <= 1'b1; // [RL11]
				end else begin
					fb_cnt_ff <= fb_cnt_ff + 32'h1;
				end
			end else begin
				fb_cnt_ff <= '0;
			end
		end
	end

	assign any_fault = (|tp.chan_err) || disc_err_ff || (|rb_err_ff) || fb_err_ff;

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ELG_ST_IDLE: begin
				if (any_fault) begin
					nxt_state = ELG_ST_FAULT;
				end else if (cond_ok && fb_closed && start_rise) begin
					nxt_state = ELG_ST_RUN; // [RL6] [RL2]
				end
			end
			ELG_ST_RUN: begin
				if (any_fault) begin
					nxt_state = ELG_ST_FAULT;
				end else if (!cond_ok) begin
					nxt_state = ELG_ST_DELAY; // [RL3]
				end
			end
			ELG_ST_DELAY: begin
				if (any_fault) begin
					nxt_state = ELG_ST_FAULT;
				end else if (dly_cnt_ff == 32'(OFF_DELAY_CYC - 1)) begin
					nxt_state = ELG_ST_IDLE; // [RL4]
				end
			end
			ELG_ST_FAULT: begin
				nxt_state = ELG_ST_FAULT;
			end
			default: begin
				nxt_state = ELG_ST_FAULT;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= ELG_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dly_cnt_ff <= '0;
		end else if (state_ff == ELG_ST_DELAY) begin
			dly_cnt_ff <= dly_cnt_ff + 32'h1; // [RL4]
		end else begin
			dly_cnt_ff <= '0;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			comb_ff <= 1'b0;
			mot_a_ff <= 1'b0;
			mot_b_ff <= 1'b0;
			en_ff <= 1'b0;
			fault_ff <= 1'b0;
			chan_err_ff <= '0;
		end else begin
			comb_ff <= cond_ok && !any_fault; // [RL3] [RL8] [RL9]
			en_ff <= (nxt_state == ELG_ST_RUN); // [RL2] [RL3] [RL11]
			// redundant pair held through the off-delay, dropped on any fault
			mot_a_ff <= (nxt_state == ELG_ST_RUN) || (nxt_state == ELG_ST_DELAY); // [RL4] [RL7] [RL11]
			mot_b_ff <= (nxt_state == ELG_ST_RUN) || (nxt_state == ELG_ST_DELAY); // [RL4] [RL7] [RL11]
			fault_ff <= any_fault;
			chan_err_ff <= tp.chan_err;
		end
	end

	assign o_test_pulse = ~pulse_low_ff;
	assign o_combined_condition_output = comb_ff;
	assign o_motor_contactor_output_a = mot_a_ff;
	assign o_motor_contactor_output_b = mot_b_ff;
	assign o_controller_enable = en_ff;
	assign o_fault = fault_ff;
	assign o_chan_err = chan_err_ff;
endmodule : elg_interlock

// File: sim/elg_interlock_chk.sv
// concurrent checks on the interlock top ports
// assumes one clock domain; bound into every elg_interlock instance
`timescale 1ns/1ps
module elg_interlock_chk #(
	parameter int OFF_DELAY_CYC = 50
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// watched inputs
	input wire logic i_start_pulse,
	input wire logic i_contactor_feedback_input,
	// watched outputs
	input wire logic [3:0] o_test_pulse,
	input wire logic o_combined_condition_output,
	input wire logic o_motor_contactor_output_a,
	input wire logic o_motor_contactor_output_b,
	input wire logic o_controller_enable,
	input wire logic o_fault,
	input wire logic [3:0] o_chan_err
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// cycles the motor has stayed on after the enable dropped
	int off_cnt_ff;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			off_cnt_ff <= 0;
		end else if (o_motor_contactor_output_a && !o_controller_enable) begin
			off_cnt_ff <= off_cnt_ff + 1;
		end else begin
			off_cnt_ff <= 0;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_enable_needs_cond: assert property (o_controller_enable |-> o_combined_condition_output)
		else $error("enable high without condition");
	a_start_gate: assert property ($rose(o_controller_enable) |-> $past(i_start_pulse, 3)
		&& !$past(o_motor_contactor_output_a) && $past(o_combined_condition_output)
		&& $past(i_contactor_feedback_input, 3)) else $error("start taken without its conditions");
	a_motor_with_en: assert property (o_controller_enable |-> o_motor_contactor_output_a)
		else $error("enable without motor");
	a_motor_pair: assert property (o_motor_contactor_output_a == o_motor_contactor_output_b)
		else $error("motor channels differ");
	a_fault_drops_all: assert property (o_fault |=> !o_combined_condition_output && !o_controller_enable
		&& !o_motor_contactor_output_a && !o_motor_contactor_output_b) else $error("output high in fault");
	a_fault_sticky: assert property (o_fault |=> o_fault)
		else $error("fault cleared without reset");
	a_chan_err_fault: assert property (|o_chan_err |-> ##[0:2] o_fault)
		else $error("channel error without fault");
	a_off_delay: assert property ($fell(o_motor_contactor_output_a) && !o_fault && !$past(o_fault)
		|-> off_cnt_ff == OFF_DELAY_CYC) else $error("off delay length wrong");
	a_one_pulse_low: assert property ($countones(~o_test_pulse) <= 1)
		else $error("two test pulses low");
endmodule : elg_interlock_chk

bind elg_interlock elg_interlock_chk #(.OFF_DELAY_CYC(OFF_DELAY_CYC)) u_chk (.i_sys_clk, .i_resetn,
	.i_start_pulse, .i_contactor_feedback_input, .o_test_pulse, .o_combined_condition_output,
	.o_motor_contactor_output_a, .o_motor_contactor_output_b, .o_controller_enable, .o_fault, .o_chan_err);

// File: sim/elg_field.sv
// field model: nc sensor channels fed by test pulses, contactors with break-contact loop
// assumes fault injection driven by the testbench at falling edges
`timescale 1ns/1ps
module elg_field (
	// clock
	input wire logic i_sys_clk,
	// test pulses and fault injection
	input wire logic [3:0] i_test_pulse,
	input wire logic [3:0] i_open,
	input wire logic [3:0] i_stuck,
	input wire logic i_fb_open,
	// contactor coils
	input wire logic i_coil_a,
	input wire logic i_coil_b,
	// returns to the interlock
	output logic [3:0] o_chan,
	output logic o_feedback
);
	logic [1:0] drop_ff;
	// a closed channel returns its own pulse; stuck models a supply short
	assign o_chan = i_stuck | (i_test_pulse & ~i_open);
	always_ff @(posedge i_sys_clk) begin
		drop_ff <= {drop_ff[0], !(i_coil_a || i_coil_b)};
	end
	// series break contacts close only once both contactors have dropped
	assign o_feedback = drop_ff[1] && !i_fb_open;
endmodule : elg_field

// File: sim/tb_elg_interlock.sv
// self-checking bench for the interlock with shortened counts
// assumes elg_field as the far side; inputs driven at falling edges
`timescale 1ns/1ps
module tb_elg_interlock import elg_pkg::*;;
	localparam int OFF = 50;
	localparam int TPP = 200;
	typedef struct {logic [3:0] stuck; logic [3:0] shrt; logic [3:0] cerr;} elg_row_s;
	elg_row_s rows [7] = '{'{4'h1, 4'h0, 4'h1}, '{4'h2, 4'h0, 4'h2}, '{4'h4, 4'h0, 4'h4},
		'{4'h8, 4'h0, 4'h8}, '{4'h0, 4'h2, 4'h0}, '{4'h0, 4'h4, 4'h0}, '{4'h0, 4'h8, 4'h0}};
	logic clk = 1'b0;
	logic rstn = 1'b1;
	logic start = 1'b0;
	logic fb_open = 1'b0;
	logic [3:0] open_m = 4'h0;
	logic [3:0] stuck_m = 4'h0;
	logic [3:0] short_m = 4'h0;
	logic [3:0] tp, chan, cerr;
	logic comb, ma, mb, en, flt, fb;
	int errors = 0;
	int check_count = 0;
	int n;
	always #2 clk = ~clk;
	elg_interlock #(.OFF_DELAY_CYC(OFF), .TP_PERIOD_CYC(TPP), .TP_LOW_CYC(8), .FB_SETTLE_CYC(20)) u_dut (
		.i_sys_clk(clk), .i_resetn(rstn), .i_curtain_channel_a_input(chan[0]),
		.i_curtain_channel_b_input(chan[1]), .i_estop_channel_a_input(chan[2]), .i_estop_channel_b_input(chan[3]),
		.i_contactor_feedback_input(fb), .i_start_pulse(start), .i_out_readback({en, mb, ma, comb} | short_m),
		.o_test_pulse(tp), .o_combined_condition_output(comb), .o_motor_contactor_output_a(ma),
		.o_motor_contactor_output_b(mb), .o_controller_enable(en), .o_fault(flt), .o_chan_err(cerr));
	elg_field u_field (.i_sys_clk(clk), .i_test_pulse(tp), .i_open(open_m), .i_stuck(stuck_m),
		.i_fb_open(fb_open), .i_coil_a(ma), .i_coil_b(mb), .o_chan(chan), .o_feedback(fb));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task summarize;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask : check
	task do_reset;
		@(negedge clk);
		rstn = 1'b0;
		repeat (8) @(negedge clk);
		check("reset pulses", 4'hf, tp);
		check("reset outputs", 6'h00, {flt, en, mb, ma, comb, |cerr});
		rstn = 1'b1;
		repeat (4) @(negedge clk);
	endtask : do_reset
	task pulse_start;
		start = 1'b0;
		@(negedge clk);
		start = 1'b1;
	endtask : pulse_start
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		summarize();
	end
	initial begin
		foreach (rows[i]) begin
			do_reset();
			stuck_m = rows[i].stuck;
			short_m = rows[i].shrt;
			n = 0;
			while (flt !== 1'b1 && n < 4 * TPP) begin
				@(negedge clk);
				n++;
			end
			repeat (2) @(negedge clk);
			check("fault", 1'b1, flt);
			check("outputs", 4'h0, {en, mb, ma, comb});
			check("chan_err", rows[i].cerr, cerr);
			stuck_m = 4'h0;
			short_m = 4'h0;
			$display("row %0d done", i);
		end
		start = 1'b1;
		do_reset();
		// act after the first curtain pulse window so no mask hides a channel
		repeat (60) @(negedge clk);
		check("held start", 2'b10, {comb, en});
		pulse_start();
		n = 0;
		while (en !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		check("run outputs", 3'h7, {en, mb, ma});
		open_m = 4'h3;
		n = 0;
		while (en !== 1'b0 && n < 10) begin
			@(negedge clk);
			n++;
		end
		check("stop fast", 1'b1, n <= 4);
		check("stop outputs", 2'b10, {ma, comb});
		open_m = 4'h0;
		pulse_start();
		n = 1;
		while (ma === 1'b1 && n < 2 * OFF) begin
			@(negedge clk);
			n++;
		end
		check("off delay", OFF, n);
		repeat (30) @(negedge clk);
		check("no restart", 1'b0, en);
		pulse_start();
		repeat (8) @(negedge clk);
		check("restart", 1'b1, en);
		$display("start stop done");
		do_reset();
		fb_open = 1'b1;
		repeat (4) @(negedge clk);
		pulse_start();
		repeat (30) @(negedge clk);
		check("loop open", 1'b0, en);
		fb_open = 1'b0;
		$display("loop test done");
		do_reset();
		pulse_start();
		repeat (8) @(negedge clk);
		open_m = 4'h4;
		repeat (6) @(negedge clk);
		check("one channel", 1'b0, en);
		open_m = 4'h0;
		repeat (10) @(negedge clk);
		check("bridged", 2'b10, {flt, ma});
		$display("bridge test done");
		summarize();
	end
endmodule : tb_elg_interlock
